/* design/ddcu_pkg.sv */
// Shared constants, field layout and enumerations of the dual channel
// command and update logic. Assumes a byte level front end in front of it.
// Behaviour
// - A write to the broadcast address is acknowledged whatever the address select pins show.
// - The broadcast address is for writes only, so a broadcast read is never acknowledged.
// - The broadcast byte 00010000 is recognised beside the own seven bit address.
// - Command 000 writes the input register, 001 updates the output, 011 does both at once.
// - Command 010 writes the input register and updates every channel in the same cycle.
// - Commands 100 to 111 set power, reset, the load mask and the reference switch.
// - Channel code 000 picks channel A, 001 picks channel B and 111 picks both.
// - An input register takes a code only when a complete word has arrived: 24 bits, or 16 in a further block.
// - With the load strobe high an unmasked output holds until an update command, while inputs may be rewritten.
// - With the load strobe low the outputs follow the input registers.
// - An output only updates if its input was written since that output last updated.
// - Each word opens with a command byte: reserved, byte selection, three command, three channel bits.
// - With the byte selection bit set further blocks are two data bytes reusing the command.
// - The data bytes carry the code left justified, high byte first.
package ddcu_pkg;

   // ****************************************************************
   // Address and field layout
   // ****************************************************************
   localparam logic [4:0] OWN_ADDR_HI = 5'h03;
   localparam logic [7:0] BCAST_BYTE = 8'h10;
   localparam int RW_BIT = 0;
   localparam int RESERVED_BIT = 7;
   localparam int BYTE_SEL_BIT = 6;
   localparam int command_field_msb = 5;
   localparam int command_field_lsb = 3;
   localparam int channel_field_msb = 2;
   localparam int channel_field_lsb = 0;
   localparam int WORD_BITS = 16;
   localparam int NUM_CH = 2;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [WORD_BITS-1:0] CODE_RST = 16'h0000;
   localparam logic [WORD_BITS-1:0] POWER_RST = 16'h0000;
   localparam logic [NUM_CH-1:0] MASK_RST = 2'h0;
   localparam logic REF_RST = 1'b0;

   // ****************************************************************
   // Enumerations
   // ****************************************************************
   typedef enum logic [2:0] {
      OP_WRITE = 3'h0,
      OP_UPDATE = 3'h1,
      OP_WRITE_UPD_ALL = 3'h2,
      OP_WRITE_UPD = 3'h3,
      OP_POWER = 3'h4,
      OP_RESET = 3'h5,
      OP_MASK = 3'h6,
      OP_REF = 3'h7
   } ddcu_op_e;

   localparam logic [2:0] CH_A = 3'h0;
   localparam logic [2:0] CH_B = 3'h1;
   localparam logic [2:0] CH_BOTH = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_CMD = 3'h3,
      ST_DHI = 3'h2,
      ST_DLO = 3'h6,
      ST_SKIP = 3'h7
   } ddcu_state_e;

endpackage

/* design/ddcu_chan_if.sv */
// Carrier between the command decoder and one channel's register pair.
// Assumes both ends run on the same clock.
interface ddcu_chan_if #(
   parameter int W = 16
);
   logic wr;
   logic upd;
   logic clr;
   logic [W-1:0] code;
   logic [W-1:0] in_code;
   logic [W-1:0] out_code;
   logic dirty;

   modport ctrl (
      output wr,
      output upd,
      output clr,
      output code,
      input in_code,
      input out_code,
      input dirty
   );

   modport chan (
      input wr,
      input upd,
      input clr,
      input code,
      output in_code,
      output out_code,
      output dirty
   );
endinterface

/* design/ddcu_chan.sv */
// Double buffered code storage of one converter channel.
// Assumes the decoder raises write requests as single cycles; update requests stay high while the load strobe is low or the channel is masked.
module ddcu_chan
   import ddcu_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   ddcu_chan_if.chan port
);

   // ****************************************************************
   // Input register and written-since-update flag
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         port.in_code <= '0;
      end else if (port.clr) begin
         port.in_code <= '0;
      end else if (port.wr) begin
         port.in_code <= port.code;
      end
   end

   // A write in the same cycle as an update is consumed by that update,
   // so the flag only stays set when no update takes the new code.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         port.dirty <= 1'b0;
      end else if (port.clr) begin
         port.dirty <= 1'b0;
      end else if (port.upd) begin
         port.dirty <= 1'b0;
      end else if (port.wr) begin
         port.dirty <= 1'b1;
      end
   end

   // ****************************************************************
   // Output register
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         port.out_code <= '0;
      end else if (port.clr) begin
         port.out_code <= '0;
      end else if (port.upd && port.wr) begin
         port.out_code <= port.code;
      end else if (port.upd && port.dirty) begin
         port.out_code <= port.in_code;
      end
   end

endmodule

/* design/ddcu_top.sv */
// Command decoder and update control of a dual channel converter.
// Assumes a byte level serial front end that reports start, stop and
// each received byte as one-cycle pulses synchronous to clk.
module ddcu_top
   import ddcu_pkg::*;
#(
   parameter int DAC_BITS = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic frame_start,
   input wire logic frame_stop,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic [1:0] addr_sel,
   input wire logic load_strobe_n,
   output logic byte_ack,
   output logic read_selected,
   output logic [NUM_CH-1:0][DAC_BITS-1:0] dac_code,
   output logic [NUM_CH-1:0][DAC_BITS-1:0] input_code,
   output logic [NUM_CH-1:0] pending,
   output logic [WORD_BITS-1:0] power_word,
   output logic [NUM_CH-1:0] load_mask,
   output logic ref_enable
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   ddcu_state_e state_reg;
   ddcu_state_e state_next;
   logic [7:0] cmd_reg;
   logic [7:0] hi_reg;
   logic byte_ack_reg;
   logic read_selected_reg;
   logic [WORD_BITS-1:0] power_reg;
   logic [NUM_CH-1:0] mask_reg;
   logic ref_reg;
   logic [7:0] own_write_byte;
   logic [7:0] own_read_byte;
   logic match_write;
   logic match_read;
   logic accept;
   logic word_done;
   logic [WORD_BITS-1:0] word;
   logic [2:0] op;
   logic [2:0] chan;
   logic [NUM_CH-1:0] chan_sel;
   logic op_writes;
   logic op_upd_sel;
   logic op_upd_all;
   logic op_power;
   logic op_reset;
   logic op_mask;
   logic op_ref;

   // ****************************************************************
   // Address match
   // ****************************************************************
   assign own_write_byte = {OWN_ADDR_HI, addr_sel, 1'b0};
   assign own_read_byte = {OWN_ADDR_HI, addr_sel, 1'b1};
   // The broadcast byte carries a clear read bit, so its read form never
   // matches and a broadcast read stays unanswered.
   assign match_write = (byte_data == own_write_byte)
      || (byte_data == BCAST_BYTE);
   assign match_read = (byte_data == own_read_byte);

   // ****************************************************************
   // Byte sequencer
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      accept = 1'b0;
      if (frame_start) begin
         state_next = ST_ADDR;
      end else if (frame_stop) begin
         state_next = ST_IDLE;
      end else if (byte_valid) begin
         case (state_reg)
            ST_ADDR: begin
               if (match_write) begin
                  accept = 1'b1;
                  state_next = ST_CMD;
               end else if (match_read) begin
                  accept = 1'b1;
                  state_next = ST_SKIP;
               end else begin
                  state_next = ST_SKIP;
               end
            end
            ST_CMD: begin
               accept = 1'b1;
               state_next = ST_DHI;
            end
            ST_DHI: begin
               accept = 1'b1;
               state_next = ST_DLO;
            end
            ST_DLO: begin
               accept = 1'b1;
               if (cmd_reg[BYTE_SEL_BIT]) begin
                  state_next = ST_DHI;
               end else begin
                  state_next = ST_CMD;
               end
            end
            ST_IDLE: begin
               state_next = ST_IDLE;
            end
            ST_SKIP: begin
               state_next = ST_SKIP;
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         byte_ack_reg <= 1'b0;
      end else begin
         byte_ack_reg <= accept;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         read_selected_reg <= 1'b0;
      end else if (frame_start || frame_stop) begin
         read_selected_reg <= 1'b0;
      end else if (byte_valid && state_reg == ST_ADDR && match_read) begin
         read_selected_reg <= 1'b1;
      end
   end

   // ****************************************************************
   // Word assembly
   // ****************************************************************
   // The reserved bit is stored but never acted upon.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_reg <= 8'h00;
      end else if (byte_valid && state_reg == ST_CMD && !frame_start
                   && !frame_stop) begin
         cmd_reg <= byte_data;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hi_reg <= 8'h00;
      end else if (byte_valid && state_reg == ST_DHI && !frame_start
                   && !frame_stop) begin
         hi_reg <= byte_data;
      end
   end

   // A word cut short by a stop or a new start never reaches a register.
   assign word_done = byte_valid && state_reg == ST_DLO
      && !frame_start && !frame_stop;
   assign word = {hi_reg, byte_data};

   // ****************************************************************
   // Command decode
   // ****************************************************************
   assign op = cmd_reg[command_field_msb:command_field_lsb];
   assign chan = cmd_reg[channel_field_msb:channel_field_lsb];

   always_comb begin
      chan_sel = '0;
      case (chan)
         CH_A: begin
            chan_sel = 2'h1;
         end
         CH_B: begin
            chan_sel = 2'h2;
         end
         CH_BOTH: begin
            chan_sel = 2'h3;
         end
         default: begin
            chan_sel = '0;
         end
      endcase
   end

   // One flag per kind of action, so the combined codes simply raise two
   // of them and the channel logic never has to decode the field itself.
   always_comb begin
      op_writes = 1'b0;
      op_upd_sel = 1'b0;
      op_upd_all = 1'b0;
      op_power = 1'b0;
      op_reset = 1'b0;
      op_mask = 1'b0;
      op_ref = 1'b0;
      case (op)
         OP_WRITE: begin
            op_writes = 1'b1;
         end
         OP_UPDATE: begin
            op_upd_sel = 1'b1;
         end
         OP_WRITE_UPD_ALL: begin
            op_writes = 1'b1;
            op_upd_all = 1'b1;
         end
         OP_WRITE_UPD: begin
            op_writes = 1'b1;
            op_upd_sel = 1'b1;
         end
         OP_POWER: begin
            op_power = 1'b1;
         end
         OP_RESET: begin
            op_reset = 1'b1;
         end
         OP_MASK: begin
            op_mask = 1'b1;
         end
         OP_REF: begin
            op_ref = 1'b1;
         end
         default: begin
            op_writes = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // Control settings
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         power_reg <= POWER_RST;
      end else if (word_done && op_reset) begin
         power_reg <= POWER_RST;
      end else if (word_done && op_power) begin
         power_reg <= word;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mask_reg <= MASK_RST;
      end else if (word_done && op_reset) begin
         mask_reg <= MASK_RST;
      end else if (word_done && op_mask) begin
         mask_reg <= word[NUM_CH-1:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ref_reg <= REF_RST;
      end else if (word_done && op_reset) begin
         ref_reg <= REF_RST;
      end else if (word_done && op_ref) begin
         ref_reg <= word[0];
      end
   end

   // ****************************************************************
   // Channels
   // ****************************************************************
   // A masked channel sees the load strobe as held low, so it updates
   // right after each write without waiting for the pin.
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      ddcu_chan_if #(.W(DAC_BITS)) cif ();

      assign cif.wr = word_done && op_writes && chan_sel[i];
      assign cif.upd = (word_done && op_upd_all)
         || (word_done && op_upd_sel && chan_sel[i])
         || !load_strobe_n
         || mask_reg[i];
      assign cif.clr = word_done && op_reset;
      assign cif.code = word[WORD_BITS-1 -: DAC_BITS];

      ddcu_chan u_chan (
         .clk(clk),
         .sys_rst(sys_rst),
         .port(cif.chan)
      );

      assign dac_code[i] = cif.out_code;
      assign input_code[i] = cif.in_code;
      assign pending[i] = cif.dirty;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign byte_ack = byte_ack_reg;
   assign read_selected = read_selected_reg;
   assign power_word = power_reg;
   assign load_mask = mask_reg;
   assign ref_enable = ref_reg;

endmodule

/* tb/ddcu_chk.sv */
// Port level checks of the dual channel command and update logic.
// Assumes it is bound into ddcu_top and shares its clock and reset.
module ddcu_chk
   import ddcu_pkg::*;
#(
   parameter int DAC_BITS = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic frame_start,
   input wire logic frame_stop,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic load_strobe_n,
   input wire logic byte_ack,
   input wire logic [NUM_CH-1:0][DAC_BITS-1:0] dac_code,
   input wire logic [NUM_CH-1:0][DAC_BITS-1:0] input_code,
   input wire logic [NUM_CH-1:0] pending,
   input wire logic [NUM_CH-1:0] load_mask
);
   // *********
   // Helpers
   // *********
   logic first_reg;
   logic taken;
   assign taken = byte_valid && !frame_start && !frame_stop;

   // The byte that follows a start is the address byte.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         first_reg <= 1'b0;
      end else if (frame_start) begin
         first_reg <= 1'b1;
      end else if (byte_valid || frame_stop) begin
         first_reg <= 1'b0;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence addr_byte(b);
      first_reg && taken && byte_data == b;
   endsequence

   sequence quiet;
      !taken;
   endsequence

   // *********
   // Checks
   // *********
   a_bcast_ack:
      assert property (addr_byte(8'h10) |=> byte_ack)
      else $error("Broadcast write address not acknowledged.");
   a_bcast_read_nak:
      assert property (addr_byte(8'h11) |=> !byte_ack)
      else $error("Broadcast read address was acknowledged.");
   a_ack_cause:
      assert property (byte_ack |-> $past(taken))
      else $error("Acknowledge without a received byte.");
   a_input_quiet:
      assert property (quiet |=> $stable(input_code))
      else $error("Input code changed with no byte received.");
   a_pend_cause:
      assert property (($rose(pending[0]) || $rose(pending[1]))
         |-> $past(taken))
      else $error("Pending flag rose with no byte received.");
   a_strobe_hold:
      assert property (quiet and load_strobe_n && load_mask == 2'h0
         |=> $stable(dac_code))
      else $error("Output code moved while the strobe was high.");
   a_strobe_follow:
      assert property (quiet and !load_strobe_n && pending[0]
         |=> dac_code[0] == $past(input_code[0]) && !pending[0])
      else $error("Output A did not follow its input under strobe.");
   a_clean_hold:
      assert property (quiet and pending == 2'h0 |=> $stable(dac_code))
      else $error("Output code moved with nothing pending.");
endmodule

bind ddcu_top ddcu_chk #(.DAC_BITS(DAC_BITS)) ddcu_chk_inst (
   .clk(clk),
   .sys_rst(sys_rst),
   .frame_start(frame_start),
   .frame_stop(frame_stop),
   .byte_valid(byte_valid),
   .byte_data(byte_data),
   .load_strobe_n(load_strobe_n),
   .byte_ack(byte_ack),
   .dac_code(dac_code),
   .input_code(input_code),
   .pending(pending),
   .load_mask(load_mask)
);

/* tb/ddcu_master.sv */
// Byte level model of the serial bus master feeding the decoder.
// Assumes one bench process calls its tasks, never two at once.
module ddcu_master (
   input wire logic clk,
   input wire logic byte_ack,
   output logic frame_start,
   output logic frame_stop,
   output logic byte_valid,
   output logic [7:0] byte_data
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      frame_start = 1'b0;
      frame_stop = 1'b0;
      byte_valid = 1'b0;
      byte_data = 8'h00;
   end

   task automatic start();
      @(posedge clk);
      #1 frame_start = 1'b1;
      @(posedge clk);
      #1 frame_start = 1'b0;
   endtask

   task automatic stop();
      @(posedge clk);
      #1 frame_stop = 1'b1;
      @(posedge clk);
      #1 frame_stop = 1'b0;
   endtask

   // A slow master idles gap cycles first; a released data bus shows
   // the inverse of the last byte so stale values never look valid.
   task automatic put(input logic [7:0] b, input int gap,
         output logic ack);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      #1 byte_valid = 1'b1;
      byte_data = b;
      @(posedge clk);
      #1 byte_valid = 1'b0;
      byte_data = ~b;
      ack = byte_ack;
   endtask
endmodule

/* tb/test_dual_dac_command_update_logic.sv */
// Self-checking bench of the dual channel command and update logic.
// Assumes the master model drives bytes and the checker is bound in.
module test_dual_dac_command_update_logic;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk, sys_rst, load_strobe_n, ack, ref_enable, read_selected;
   logic frame_start, frame_stop, byte_valid, byte_ack;
   logic [7:0] byte_data;
   logic [1:0] addr_sel, pending, load_mask;
   logic [1:0][15:0] dac_code, input_code;
   logic [15:0] power_word;
   int errors, n_compared, cycles;

   ddcu_top #(.DAC_BITS(16)) ddcu_top_inst (.clk(clk), .sys_rst(sys_rst),
      .frame_start(frame_start), .frame_stop(frame_stop),
      .byte_valid(byte_valid), .byte_data(byte_data),
      .addr_sel(addr_sel), .load_strobe_n(load_strobe_n),
      .byte_ack(byte_ack), .read_selected(read_selected),
      .dac_code(dac_code), .input_code(input_code), .pending(pending),
      .power_word(power_word), .load_mask(load_mask),
      .ref_enable(ref_enable));

   ddcu_master ddcu_master_inst (.clk(clk), .byte_ack(byte_ack),
      .frame_start(frame_start), .frame_stop(frame_stop),
      .byte_valid(byte_valid), .byte_data(byte_data));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Whole run needs well under a thousand cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         report_and_stop();
      end
   end

   // *********
   // Tasks
   // *********
   task automatic report_and_stop();
      $display("Compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic send(input logic [7:0] b, input logic exp);
      ddcu_master_inst.put(b, 0, ack);
      check("byte_ack", 32'(exp), 32'(ack));
   endtask

   task automatic word(input logic [7:0] c, input logic [15:0] v);
      send(c, 1'b1);
      send(v[15:8], 1'b1);
      send(v[7:0], 1'b1);
   endtask

   task automatic wr(input logic [7:0] c, input logic [15:0] v);
      ddcu_master_inst.start();
      send(8'h10, 1'b1);
      word(c, v);
      ddcu_master_inst.stop();
   endtask

   task automatic all_zero();
      check("dac_code", 32'h0, dac_code);
      check("input_code", 32'h0, input_code);
      check("flags", 32'h0,
         32'({pending, load_mask, power_word, ref_enable}));
   endtask

   // *********
   // Tests
   // *********
   initial begin
      errors = 0;
      n_compared = 0;
      cycles = 0;
      sys_rst = 1'b1;
      load_strobe_n = 1'b1;
      addr_sel = 2'h0;
      repeat (2) @(posedge clk);
      #1 sys_rst = 1'b0;
      all_zero();
      for (int i = 0; i < 4; i++) begin
         addr_sel = 2'(i);
         wr(8'h18, 16'h1230 + 16'(i));
         check("dac_code", 32'h1230 + 32'(i), dac_code);
      end
      ddcu_master_inst.start();
      send(8'h11, 1'b0);
      send(8'h18, 1'b0);
      ddcu_master_inst.stop();
      ddcu_master_inst.start();
      send({5'h03, addr_sel, 1'b1}, 1'b1);
      check("read_selected", 32'h1, 32'(read_selected));
      ddcu_master_inst.stop();
      wr(8'h00, 16'hBEEF);
      check("input_code", 32'h0000BEEF, input_code);
      check("dac_code", 32'h00001233, dac_code);
      check("pending", 32'h1, 32'(pending));
      @(posedge clk);
      #1 load_strobe_n = 1'b0;
      @(posedge clk);
      #1 load_strobe_n = 1'b1;
      check("dac_code", 32'h0000BEEF, dac_code);
      check("pending", 32'h0, 32'(pending));
      @(posedge clk);
      #1 load_strobe_n = 1'b0;
      wr(8'h01, 16'hCAFE);
      check("dac_code", 32'hCAFEBEEF, dac_code);
      load_strobe_n = 1'b1;
      wr(8'h01, 16'h0F0F);
      wr(8'h09, 16'hFFFF);
      check("dac_code", 32'h0F0FBEEF, dac_code);
      check("input_code", 32'h0F0FBEEF, input_code);
      wr(8'h01, 16'h2222);
      wr(8'h10, 16'h3333);
      check("dac_code", 32'h22223333, dac_code);
      check("pending", 32'h0, 32'(pending));
      wr(8'h1F, 16'h4444);
      check("dac_code", 32'h44444444, dac_code);
      for (int c = 2; c < 7; c++) begin
         wr({5'h03, 3'(c)}, 16'h5555);
         check("dac_code", 32'h44444444, dac_code);
         check("input_code", 32'h44444444, input_code);
      end
      ddcu_master_inst.start();
      send(8'h10, 1'b1);
      word(8'h18, 16'h8888);
      word(8'h19, 16'h9999);
      ddcu_master_inst.stop();
      check("dac_code", 32'h99998888, dac_code);
      ddcu_master_inst.start();
      send(8'h10, 1'b1);
      word(8'h59, 16'h6666);
      check("dac_code", 32'h66668888, dac_code);
      ddcu_master_inst.put(8'h77, 3, ack);
      check("byte_ack", 32'h1, 32'(ack));
      send(8'h01, 1'b1);
      check("dac_code", 32'h77018888, dac_code);
      ddcu_master_inst.stop();
      ddcu_master_inst.start();
      send(8'h10, 1'b1);
      send(8'h1F, 1'b1);
      send(8'h12, 1'b1);
      ddcu_master_inst.stop();
      check("dac_code", 32'h77018888, dac_code);
      wr(8'h20, 16'hABCD);
      check("power_word", 32'h0000ABCD, 32'(power_word));
      wr(8'h30, 16'h0002);
      check("load_mask", 32'h2, 32'(load_mask));
      wr(8'h01, 16'h1357);
      check("dac_code", 32'h13578888, dac_code);
      wr(8'h38, 16'h0001);
      check("ref_enable", 32'h1, 32'(ref_enable));
      wr(8'h28, 16'h0000);
      all_zero();
      report_and_stop();
   end
endmodule
